/* verilog/decode_assist_pkg.sv */
// Constants, kinds and states shared by the decode assist unit.
// Assumes one core clock and a synchronous active-high reset.
// Overview of operation
// - Feature identification bit reads one since the assist fields exist.
// - Control register move exit: operand in 3:0, zeros 62:4, bit 63 set.
// - Debug register move exit: operand in 3:0, zeros in 63:4.
// - Load status word or clear task switched: no operand, bit 63 clear.
// - Register zero read: move gives operand and bit 63; store gives nothing.
// - Software interrupt exit: immediate number in 7:0, zeros above.
// - Page invalidate exit: full linear address after base add and masking.
// - Tagged page invalidate exit: no address given; hypervisor reads accumulator.
// - Nested or intercepted page fault: opcode bytes stored at block offset D0.
// - Fetch fifteen bytes unless a fault stops it; keep bytes obtained.
// - Count in bits 3:0, zeros in 7:4, opcode bytes in 127:8.
// - Fill bytes only on data page faults, never on fetch faults.
// - Every other exit clears bits 7:0; upper bytes may stay.
// - Status word accesses: non-memory faults, then intercept, then memory faults.
// - Table base access: non-memory faults first; write exit precedes flush.
// - Pointer entry protection fault checked only after the table base intercept.
// - Implicit table base accesses by entry, exit or task switch never intercept.
// - Other control register moves: all exception checks precede the intercept.
package decode_assist_pkg;

    // Intercepted instruction or event class
    typedef enum logic [3:0] {
        KIND_CTRL_TO     = 4'h0,
        KIND_CTRL_FROM   = 4'h1,
        KIND_LOAD_STATUS = 4'h2,
        KIND_CLEAR_TS    = 4'h3,
        KIND_STORE_STAT  = 4'h4,
        KIND_DBG_MOV     = 4'h5,
        KIND_SOFT_INT    = 4'h6,
        KIND_PAGE_INV    = 4'h7,
        KIND_TAGGED_INV  = 4'h8,
        KIND_NESTED_PF   = 4'h9,
        KIND_GUEST_PF    = 4'hA,
        KIND_OTHER       = 4'hB
    } kind_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_DECIDE = 3'h1,
        ST_FETCH  = 3'h2,
        ST_WRITE  = 3'h3,
        ST_EXIT   = 3'h4
    } state_e;

    localparam logic [11:0]  OPCODE_FIELD_OFFSET = 12'h0D0;
    localparam logic         DECODE_HELP_BIT     = 1'h1;
    localparam logic [3:0]   TABLE_BASE_SEL      = 4'h3;
    localparam logic [3:0]   FETCH_LAST          = 4'hE;
    localparam int           FETCH_MAX           = 15;
    localparam int           QUAL_CTRL_FLAG      = 63;
    localparam logic [1:0]   ASZ_16              = 2'h0;
    localparam logic [1:0]   ASZ_32              = 2'h1;
    localparam logic [1:0]   EXC_NONE            = 2'h0;
    localparam logic [1:0]   EXC_NON_MEMORY      = 2'h1;
    localparam logic [1:0]   EXC_MEMORY          = 2'h2;
    localparam logic [1:0]   EXC_PROTECTION      = 2'h3;
    localparam logic [63:0]  QUAL_RESET          = 64'h0;
    localparam logic [127:0] FIELD_RESET         = 128'h0;

endpackage

/* verilog/exit_qualifier_former.sv */
// Combinational former of the 64-bit exit qualifier.
// Assumes inputs are held stable by the caller's snapshot registers.
module exit_qualifier_former (
    input  wire logic [3:0]  kind_i,
    input  wire logic [3:0]  operand_i,
    input  wire logic [7:0]  int_num_i,
    input  wire logic [63:0] eff_addr_i,
    input  wire logic [63:0] seg_base_i,
    input  wire logic [1:0]  addr_size_i,
    output logic      [63:0] qual_o
);
    // mask to address size, add base, trim outside long mode
    wire [63:0] masked  = (addr_size_i == decode_assist_pkg::ASZ_16) ? {48'h0, eff_addr_i[15:0]}
                        : (addr_size_i == decode_assist_pkg::ASZ_32) ? {32'h0, eff_addr_i[31:0]}
                        : eff_addr_i;
    wire [63:0] lin_sum = seg_base_i + masked;
    wire [63:0] linear  = (addr_size_i == decode_assist_pkg::ASZ_16 ||
                           addr_size_i == decode_assist_pkg::ASZ_32) ? {32'h0, lin_sum[31:0]}
                        : lin_sum;
    wire is_ctrl_mov    = kind_i == decode_assist_pkg::KIND_CTRL_TO ||
                          kind_i == decode_assist_pkg::KIND_CTRL_FROM;

    // field layouts; status word kinds fall to zero
    assign qual_o = is_ctrl_mov ? {1'h1, 59'h0, operand_i}
                  : (kind_i == decode_assist_pkg::KIND_DBG_MOV) ? {60'h0, operand_i}
                  : (kind_i == decode_assist_pkg::KIND_SOFT_INT) ? {56'h0, int_num_i}
                  : (kind_i == decode_assist_pkg::KIND_PAGE_INV) ? linear
                  : decode_assist_pkg::QUAL_RESET;
endmodule

/* verilog/opcode_byte_collector.sv */
// Fetches up to fifteen guest opcode bytes, one per accepted beat.
// Assumes the fetch unit answers a held request with valid, byte and fault.
module opcode_byte_collector (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         start_i,
    input  wire logic         fetch_valid_i,
    input  wire logic [7:0]   fetch_byte_i,
    input  wire logic         fetch_fault_i,
    output logic              fetch_req_o,
    output logic [3:0]        fetch_index_o,
    output logic              done_o,
    output logic [127:0]      field_o
);
    logic [7:0] bytes [0:14];
    logic [3:0] count;

    // a fault ends the fetch early, keeping what came
    wire take  = fetch_req_o && fetch_valid_i && !fetch_fault_i;
    wire fault = fetch_req_o && fetch_valid_i && fetch_fault_i;
    wire stop  = fault || (take && count == decode_assist_pkg::FETCH_LAST);

    // Request, count and completion
    always_ff @(posedge clock_i)
    begin
        if (rst_i || start_i)
            count <= 4'h0;
        else if (take)
            count <= count + 4'h1;
        fetch_req_o <= !rst_i && (start_i || (fetch_req_o && !stop));
        done_o      <= !rst_i && stop;
    end

    // count in 3:0, zeros in 7:4, bytes above
    assign fetch_index_o = count;
    assign field_o[7:0]  = {4'h0, count};

    // Per-byte storage, cleared at start so unfetched bytes read zero
    for (genvar i = 0; i < decode_assist_pkg::FETCH_MAX; i++)
    begin : g_byte
        always_ff @(posedge clock_i)
        begin
            if (rst_i || start_i)
                bytes[i] <= 8'h00;
            else if (take && count == 4'(i))
                bytes[i] <= fetch_byte_i;
        end
        assign field_o[8*i+15 -: 8] = bytes[i];
    end
endmodule

/* verilog/decode_assist_unit.sv */
// Exit-path decode assist: qualifier, opcode byte field and the
// intercept versus exception ordering for control register accesses.
// Assumes event inputs come from core logic on clock_i; no synchronisers.
module decode_assist_unit (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         event_i,
    input  wire logic [3:0]   kind_i,
    input  wire logic [3:0]   ctrl_sel_i,
    input  wire logic         is_write_i,
    input  wire logic [3:0]   operand_reg_i,
    input  wire logic [7:0]   int_num_i,
    input  wire logic [63:0]  eff_addr_i,
    input  wire logic [63:0]  seg_base_i,
    input  wire logic [1:0]   addr_size_i,
    input  wire logic         data_fault_i,
    input  wire logic         implicit_i,
    input  wire logic         intercept_on_i,
    input  wire logic         non_mem_exc_i,
    input  wire logic         mem_exc_i,
    input  wire logic         phys_ext_on_i,
    input  wire logic         pointer_bad_i,
    input  wire logic         fetch_valid_i,
    input  wire logic [7:0]   fetch_byte_i,
    input  wire logic         fetch_fault_i,
    output logic              fetch_req_o,
    output logic [3:0]        fetch_index_o,
    output logic              busy_o,
    output logic [63:0]       exit_qualifier_one_o,
    output logic [127:0]      guest_fetched_opcode_bytes_o,
    output logic              block_wr_o,
    output logic [11:0]       block_addr_o,
    output logic              exit_o,
    output logic              exception_o,
    output logic [1:0]        exception_code_o,
    output logic              tlb_flush_o,
    output logic              decode_help_supported_o
);
    decode_assist_pkg::state_e st;
    decode_assist_pkg::state_e next_st;
    decode_assist_pkg::kind_e  kind;

    logic [3:0]  ctrl_sel;
    logic        is_wr;
    logic [3:0]  operand;
    logic [7:0]  int_num;
    logic [63:0] eff_addr;
    logic [63:0] seg_base;
    logic [1:0]  addr_size;
    logic        data_fault;
    logic        implicit;
    logic        icpt_on;
    logic        non_mem_exc;
    logic        mem_exc;
    logic        phys_ext_on;
    logic        pointer_bad;
    logic        fetched;

    wire         accept = (st == decode_assist_pkg::ST_IDLE) && event_i;
    wire [63:0]  qual_w;
    wire         col_start;
    wire         col_done;
    wire [127:0] col_field;

    // Snapshot of the event so decisions see stable operands
    always_ff @(posedge clock_i)
    begin
        if (accept)
        begin
            kind        <= decode_assist_pkg::kind_e'(kind_i);
            ctrl_sel    <= ctrl_sel_i;
            is_wr       <= is_write_i;
            operand     <= operand_reg_i;
            int_num     <= int_num_i;
            eff_addr    <= eff_addr_i;
            seg_base    <= seg_base_i;
            addr_size   <= addr_size_i;
            data_fault  <= data_fault_i;
            implicit    <= implicit_i;
            icpt_on     <= intercept_on_i;
            non_mem_exc <= non_mem_exc_i;
            mem_exc     <= mem_exc_i;
            phys_ext_on <= phys_ext_on_i;
            pointer_bad <= pointer_bad_i;
        end
    end

    // Access classes
    wire ctrl_mov   = kind == decode_assist_pkg::KIND_CTRL_TO ||
                      kind == decode_assist_pkg::KIND_CTRL_FROM;
    wire status_wd  = kind == decode_assist_pkg::KIND_LOAD_STATUS ||
                      kind == decode_assist_pkg::KIND_STORE_STAT;
    wire other_ctrl = kind == decode_assist_pkg::KIND_CLEAR_TS ||
                      kind == decode_assist_pkg::KIND_DBG_MOV ||
                      (ctrl_mov && ctrl_sel != decode_assist_pkg::TABLE_BASE_SEL);
    wire table_base = ctrl_mov && ctrl_sel == decode_assist_pkg::TABLE_BASE_SEL;
    wire checked    = status_wd || other_ctrl || table_base;
    wire page_fault = kind == decode_assist_pkg::KIND_NESTED_PF ||
                      kind == decode_assist_pkg::KIND_GUEST_PF;

    // implicit table base accesses skip the intercept
    wire icpt_eff = icpt_on && !(table_base && implicit);

    // non-memory faults, intercept, then memory faults
    wire [1:0] exc_status = non_mem_exc ? decode_assist_pkg::EXC_NON_MEMORY
                          : icpt_eff    ? decode_assist_pkg::EXC_NONE
                          : mem_exc     ? decode_assist_pkg::EXC_MEMORY
                          : decode_assist_pkg::EXC_NONE;

    // non-memory faults first, then the intercept
    // pointer entry protection fault only after the intercept
    wire [1:0] exc_table  = non_mem_exc ? decode_assist_pkg::EXC_NON_MEMORY
                          : icpt_eff    ? decode_assist_pkg::EXC_NONE
                          : (phys_ext_on && is_wr && pointer_bad)
                                        ? decode_assist_pkg::EXC_PROTECTION
                          : decode_assist_pkg::EXC_NONE;

    // every normal exception precedes the intercept
    wire [1:0] exc_other  = non_mem_exc ? decode_assist_pkg::EXC_NON_MEMORY
                          : mem_exc     ? decode_assist_pkg::EXC_MEMORY
                          : decode_assist_pkg::EXC_NONE;

    wire [1:0] exc_sel    = status_wd  ? exc_status
                          : table_base ? exc_table
                          : other_ctrl ? exc_other
                          : decode_assist_pkg::EXC_NONE;

    // Non-checked kinds arrive only as intercepts, so they always exit
    wire dec_exc   = exc_sel != decode_assist_pkg::EXC_NONE;
    wire dec_exit  = !dec_exc && (!checked || icpt_eff);
    wire dec_flush = table_base && is_wr && !dec_exc && !dec_exit;

    // fetch only for nested or intercepted faults
    // and only when the fault came from a data access
    wire need_fetch = page_fault && data_fault;
    assign col_start = (st == decode_assist_pkg::ST_DECIDE) && dec_exit && need_fetch;

    // status word and tagged kinds form zero
    exit_qualifier_former u_former (
        .kind_i      (kind),
        .operand_i   (operand),
        .int_num_i   (int_num),
        .eff_addr_i  (eff_addr),
        .seg_base_i  (seg_base),
        .addr_size_i (addr_size),
        .qual_o      (qual_w)
    );

    opcode_byte_collector u_collector (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .start_i       (col_start),
        .fetch_valid_i (fetch_valid_i),
        .fetch_byte_i  (fetch_byte_i),
        .fetch_fault_i (fetch_fault_i),
        .fetch_req_o   (fetch_req_o),
        .fetch_index_o (fetch_index_o),
        .done_o        (col_done),
        .field_o       (col_field)
    );

    // Sequencer: one event at a time, exit only after the writes
    always_comb
    begin
        next_st = st;
        case (st)
            decode_assist_pkg::ST_IDLE:
                if (event_i)
                    next_st = decode_assist_pkg::ST_DECIDE;
            decode_assist_pkg::ST_DECIDE:
                if (!dec_exit)
                    next_st = decode_assist_pkg::ST_IDLE;
                else if (need_fetch)
                    next_st = decode_assist_pkg::ST_FETCH;
                else
                    next_st = decode_assist_pkg::ST_WRITE;
            decode_assist_pkg::ST_FETCH:
                if (col_done)
                    next_st = decode_assist_pkg::ST_WRITE;
            decode_assist_pkg::ST_WRITE:
                next_st = decode_assist_pkg::ST_EXIT;
            decode_assist_pkg::ST_EXIT:
                next_st = decode_assist_pkg::ST_IDLE;
            default:
                next_st = decode_assist_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            st <= decode_assist_pkg::ST_IDLE;
        else
            st <= next_st;
        busy_o <= !rst_i && next_st != decode_assist_pkg::ST_IDLE;
    end

    // Remember whether this exit carries fetched bytes
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            fetched <= 1'h0;
        else if (st == decode_assist_pkg::ST_DECIDE)
            fetched <= need_fetch;
    end

    always_ff @(posedge clock_i)
    begin
        decode_help_supported_o <= decode_assist_pkg::DECODE_HELP_BIT;
        block_addr_o            <= decode_assist_pkg::OPCODE_FIELD_OFFSET;
    end

    // qualifier latched once per exit, before the field write
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            exit_qualifier_one_o <= decode_assist_pkg::QUAL_RESET;
        else if (st == decode_assist_pkg::ST_DECIDE && dec_exit)
            exit_qualifier_one_o <= qual_w;
    end

    // other exits clear only the low byte; upper bytes kept
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            guest_fetched_opcode_bytes_o <= decode_assist_pkg::FIELD_RESET;
        else if (st == decode_assist_pkg::ST_WRITE && fetched)
            guest_fetched_opcode_bytes_o <= col_field;
        else if (st == decode_assist_pkg::ST_WRITE)
            guest_fetched_opcode_bytes_o[7:0] <= 8'h00;
    end

    // field write strobe, then the exit one cycle later
    // flush only when no write exit was taken
    always_ff @(posedge clock_i)
    begin
        block_wr_o       <= !rst_i && st == decode_assist_pkg::ST_WRITE;
        exit_o           <= !rst_i && st == decode_assist_pkg::ST_EXIT;
        exception_o      <= !rst_i && st == decode_assist_pkg::ST_DECIDE && dec_exc;
        exception_code_o <= (!rst_i && st == decode_assist_pkg::ST_DECIDE)
                            ? exc_sel : decode_assist_pkg::EXC_NONE;
        tlb_flush_o      <= !rst_i && st == decode_assist_pkg::ST_DECIDE && dec_flush;
    end

    // Checks on the exit path
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    wire deciding = st == decode_assist_pkg::ST_DECIDE;

    sequence s_write_step;
        block_wr_o && !exit_o;
    endsequence

    sequence s_exit_step;
        exit_o && !block_wr_o;
    endsequence

    localparam int QUAL_BIT = decode_assist_pkg::QUAL_CTRL_FLAG;

    a_feature_bit:
    assert property (##1 decode_help_supported_o == 1'h1)
        else $error("feature bit not one");

    a_ctrl_qual_form:
    assert property (deciding && dec_exit && ctrl_mov |=>
        exit_qualifier_one_o[QUAL_BIT] && exit_qualifier_one_o[62:4] == 59'h0 &&
        exit_qualifier_one_o[3:0] == $past(operand))
        else $error("control move qualifier wrong");

    a_dbg_qual_form:
    assert property (deciding && dec_exit && kind == decode_assist_pkg::KIND_DBG_MOV |=>
        exit_qualifier_one_o == {60'h0, $past(operand)})
        else $error("debug move qualifier wrong");

    a_load_clear_none:
    assert property (deciding && dec_exit &&
        (kind == decode_assist_pkg::KIND_LOAD_STATUS ||
         kind == decode_assist_pkg::KIND_CLEAR_TS) |=> exit_qualifier_one_o == 64'h0)
        else $error("load or clear gave operand");

    a_store_no_info:
    assert property (deciding && dec_exit && kind == decode_assist_pkg::KIND_STORE_STAT |=>
        !exit_qualifier_one_o[QUAL_BIT] && exit_qualifier_one_o == 64'h0)
        else $error("store status gave information");

    a_soft_int_form:
    assert property (deciding && dec_exit && kind == decode_assist_pkg::KIND_SOFT_INT |=>
        exit_qualifier_one_o == {56'h0, $past(int_num)})
        else $error("interrupt number wrong");

    a_long_linear:
    assert property (deciding && dec_exit && kind == decode_assist_pkg::KIND_PAGE_INV &&
        addr_size == 2'h2 |=> exit_qualifier_one_o == $past(seg_base) + $past(eff_addr))
        else $error("linear address wrong");

    a_tagged_none:
    assert property (deciding && dec_exit && kind == decode_assist_pkg::KIND_TAGGED_INV |=>
        exit_qualifier_one_o == 64'h0)
        else $error("tagged invalidate gave address");

    a_fetch_starts:
    assert property (deciding && page_fault && data_fault |=> fetch_req_o)
        else $error("page fault fetch not started");

    a_fetch_bounded:
    assert property (col_start |-> ##[1:40] col_done)
        else $error("fetch did not finish");

    a_field_layout:
    assert property (block_wr_o && fetched |->
        guest_fetched_opcode_bytes_o[7:0] == {4'h0, fetch_index_o})
        else $error("byte field layout wrong");

    a_ifetch_no_fill:
    assert property (deciding && page_fault && !data_fault |=> !fetch_req_o)
        else $error("fetch fault filled bytes");

    a_other_clears:
    assert property (st == decode_assist_pkg::ST_WRITE && !fetched |=>
        guest_fetched_opcode_bytes_o[7:0] == 8'h00 &&
        guest_fetched_opcode_bytes_o[127:8] == $past(guest_fetched_opcode_bytes_o[127:8]))
        else $error("low byte not cleared");

    a_status_order:
    assert property (deciding && status_wd && !non_mem_exc && icpt_on && mem_exc |=>
        !exception_o ##1 busy_o)
        else $error("memory fault beat intercept");

    a_table_flush:
    assert property (deciding && table_base && is_wr && icpt_eff && !non_mem_exc |=>
        !tlb_flush_o && !exception_o)
        else $error("flush before write exit");

    a_pointer_late:
    assert property (deciding && table_base && phys_ext_on && pointer_bad &&
        is_wr && !icpt_eff && !non_mem_exc |=>
        exception_code_o == decode_assist_pkg::EXC_PROTECTION)
        else $error("pointer fault missed");

    a_implicit_skip:
    assert property (deciding && table_base && implicit |=> !busy_o)
        else $error("implicit access intercepted");

    a_other_exc_first:
    assert property (deciding && other_ctrl && (non_mem_exc || mem_exc) |=>
        exception_o && !busy_o)
        else $error("intercept beat exception");

    a_write_then_exit:
    assert property (s_write_step |=> s_exit_step)
        else $error("exit not after field write");
endmodule

/* verification/decode_assist_unit_tb.sv */
// Self-checking bench for the decode assist unit.
// Assumes the hand-over timing; the bench itself answers opcode fetches.
module decode_assist_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clock_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         event_i = 1'b0;
    logic [3:0]   kind_i = 4'h0;
    logic [3:0]   ctrl_sel_i = 4'h0;
    logic [3:0]   operand_reg_i = 4'h0;
    logic [7:0]   int_num_i = 8'h0;
    logic [63:0]  eff_addr_i = 64'h0;
    logic [63:0]  seg_base_i = 64'h0;
    logic [1:0]   addr_size_i = 2'h0;
    logic         is_write_i = 1'b0, data_fault_i = 1'b0, implicit_i = 1'b0;
    logic         intercept_on_i = 1'b0, non_mem_exc_i = 1'b0, mem_exc_i = 1'b0;
    logic         phys_ext_on_i = 1'b0, pointer_bad_i = 1'b0;
    logic         fetch_valid_i = 1'b0, fetch_fault_i = 1'b0;
    logic [7:0]   fetch_byte_i = 8'h0;
    logic         fetch_req_o, busy_o, block_wr_o, exit_o, exception_o;
    logic         tlb_flush_o, decode_help_supported_o;
    logic [3:0]   fetch_index_o;
    logic [1:0]   exception_code_o;
    logic [11:0]  block_addr_o;
    logic [63:0]  exit_qualifier_one_o;
    logic [127:0] guest_fetched_opcode_bytes_o;
    logic [7:0]   salt = 8'h0;
    logic [4:0]   fault_at = 5'h10;
    logic [4:0]   res;
    logic         wr_seen;
    logic [3:0]   k;
    logic [23:0]  pt [12] = '{24'h04E005, 24'h04D006, 24'h20D010, 24'h20E005, 24'h405010,
        24'h03E005, 24'h03C010, 24'h038008, 24'h03CC10, 24'h038C07, 24'h134200, 24'h50E005};
    int           error_cnt = 0, checks = 0, cyc = 0;

    decode_assist_unit dut_u (.clock_i, .rst_i, .event_i, .kind_i, .ctrl_sel_i, .is_write_i,
        .operand_reg_i, .int_num_i, .eff_addr_i, .seg_base_i, .addr_size_i, .data_fault_i,
        .implicit_i, .intercept_on_i, .non_mem_exc_i, .mem_exc_i, .phys_ext_on_i,
        .pointer_bad_i, .fetch_valid_i, .fetch_byte_i, .fetch_fault_i, .fetch_req_o,
        .fetch_index_o, .busy_o, .exit_qualifier_one_o, .guest_fetched_opcode_bytes_o,
        .block_wr_o, .block_addr_o, .exit_o, .exception_o, .exception_code_o, .tlb_flush_o,
        .decode_help_supported_o);

    always #12.5 clock_i = ~clock_i;

    // Slow fetch side: answers every other cycle so a stale index is never reused
    always @(posedge clock_i)
    begin
        fetch_valid_i <= fetch_req_o && !fetch_valid_i && !rst_i;
        fetch_byte_i  <= salt + 8'(fetch_index_o);
        fetch_fault_i <= {1'b0, fetch_index_o} == fault_at;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One event with fresh operands; gathers every pulse until busy drops
    task automatic ev(input logic [3:0] kk, input logic [3:0] sel, input logic [7:0] fl);
        @(posedge clock_i);
        kind_i <= kk;
        ctrl_sel_i <= sel;
        {is_write_i, intercept_on_i, non_mem_exc_i, mem_exc_i, phys_ext_on_i,
            pointer_bad_i, implicit_i, data_fault_i} <= fl;
        operand_reg_i <= 4'($urandom);
        int_num_i <= 8'($urandom);
        eff_addr_i <= {$urandom, $urandom};
        seg_base_i <= {$urandom, $urandom};
        addr_size_i <= 2'($urandom);
        event_i <= 1'b1;
        @(posedge clock_i);
        event_i <= 1'b0;
        res = 5'h0;
        wr_seen = 1'b0;
        for (int n = 0; n < 200 && (n < 3 || busy_o); n++)
        begin
            @(negedge clock_i);
            res |= {exit_o, tlb_flush_o, exception_o, exception_code_o};
            wr_seen |= block_wr_o;
        end
    endtask

    // Expected qualifier per kind; offset masked to size, base added, 32 bits below 64-bit
    function automatic logic [63:0] qexp(input logic [3:0] kk);
        logic [63:0] t;
        t = addr_size_i == 2'h0 ? {48'h0, eff_addr_i[15:0]} :
            addr_size_i == 2'h1 ? {32'h0, eff_addr_i[31:0]} : eff_addr_i;
        t = t + seg_base_i;
        case (kk)
            4'h0, 4'h1: return {1'b1, 59'h0, operand_reg_i};
            4'h5: return {60'h0, operand_reg_i};
            4'h6: return {56'h0, int_num_i};
            4'h7: return addr_size_i[1] ? t : {32'h0, t[31:0]};
            default: return 64'h0;
        endcase
    endfunction

    // Expected byte field: count low, zero nibble, unfetched bytes zero
    function automatic logic [127:0] fld(input logic [4:0] f, input logic [7:0] s);
        logic [127:0] t;
        int cnt;
        cnt = f > 15 ? 15 : f;
        t = 128'(cnt);
        for (int i = 0; i < cnt; i++) t[8*i+8 +: 8] = s + 8'(i);
        return t;
    endfunction

    // Reset, every kind three times over fault corners, then ordering table
    initial
    begin
        void'($urandom(32'h7854374E));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        check(128'({busy_o, exit_qualifier_one_o}), 128'h0, "reset");
        check(guest_fetched_opcode_bytes_o, 128'h0, "reset field");
        for (int r = 0; r < 36; r++)
        begin
            k = 4'(r % 12);
            salt = 8'($urandom);
            fault_at = r < 12 ? 5'h10 : r < 24 ? 5'h0 : 5'($urandom_range(15));
            ev(k, 4'($urandom), {1'($urandom), 1'b1, 5'h0, 1'(r < 12 || r > 23)});
            check(res, 5'h10, "exit");
            check(wr_seen, 1'b1, "field write");
            if (k < 4'h9) check(exit_qualifier_one_o, qexp(k), "qual");
            if (k > 4'h8 && k < 4'hB && (r < 12 || r > 23))
            begin
                check(guest_fetched_opcode_bytes_o, fld(fault_at, salt), "fill");
                check({fetch_req_o, fetch_index_o},
                    {1'b0, r < 12 ? 4'hF : 4'(fault_at)}, "count");
            end
            else
                check(guest_fetched_opcode_bytes_o[7:0], 8'h0, "clear");
        end
        foreach (pt[i])
        begin
            ev(pt[i][23:20], pt[i][19:16], pt[i][15:8]);
            check(res, pt[i][4:0], "order");
            check(wr_seen, pt[i][4], "order write");
        end
        check({decode_help_supported_o, block_addr_o}, {1'b1, 12'h0D0}, "ident");
        conclude();
    end
endmodule
